// ==== caa_cfg.svh ====
// Constants for the converter alarm aggregator
`ifndef CAA_CFG_SVH
`define CAA_CFG_SVH
`define CAA_ADDR_W 15
`define CAA_ADDR_SUMMARY 15'h02c0
`define CAA_ADDR_FLAGS 15'h02c1
`define CAA_ADDR_DISABLE 15'h02c2
`define CAA_ADDR_LANE_LO 15'h02c4
`define CAA_ADDR_LANE_HI 15'h02c5
`define CAA_NUM_ALARMS 6
`define CAA_NUM_LANES 16
`define CAA_FLAGS_RESET 6'h3f
`define CAA_DISABLE_RESET 6'h3f
`define CAA_LANE_RESET 16'hffff
`define CAA_BIT_DIVIDER 0
`define CAA_BIT_OSC 1
`define CAA_BIT_REALIGN 2
`define CAA_BIT_LINK 3
`define CAA_BIT_LOCK 4
`define CAA_BIT_LANE 5
`define CAA_BIT_SUMMARY 0
`define CAA_PIN_SEL_ALARM 2'h1
`endif

// ==== caa_pkg.sv ====
// Types for the converter alarm aggregator
package caa_pkg;
  typedef logic [7:0] caa_byte_t;
  typedef enum logic {CAA_MODE_8B10B, CAA_MODE_64B66B} caa_encoding_e;
endpackage : caa_pkg

// ==== caa_sync.sv ====
// Three-stage synchroniser with agreement on the last two stages
`timescale 1ns/1ps
`default_nettype none
module caa_sync #(
  parameter int W = 1
) (
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] sync_o
);
  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;
  logic [W-1:0] held;
  logic [W-1:0] next_held;

  always_comb begin
    next_held = held;
    for (int i = 0; i < W; i++) begin
      if (s2[i] == s3[i]) begin
        next_held[i] = s3[i];
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
      held <= '0;
    end else begin
      s1 <= async_i;
      s2 <= s1;
      s3 <= s2;
      held <= next_held;
    end
  end

  assign sync_o = held;
endmodule : caa_sync
`default_nettype wire

// ==== caa_alarm_aggregator.sv ====
// Alarm flags, disable mask, per-lane faults and summary for the converter
`include "caa_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module caa_alarm_aggregator (
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  input wire logic soft_reset_i,
  // Register port
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [`CAA_ADDR_W-1:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  output caa_pkg::caa_byte_t reg_rdata_o,
  output logic reg_rvalid_o,
  // Fault sources from other clock domains, and the unsynchronised encoding setting
  input wire logic [`CAA_NUM_LANES-1:0] lane_buffer_fault_i,
  input wire logic [`CAA_NUM_LANES-1:0] lane_active_i,
  input wire logic pll_locked_i,
  input wire logic link_enable_i,
  input wire caa_pkg::caa_encoding_e link_encoding_i,
  input wire logic link_in_data_state_i,
  input wire logic link_realign_i,
  input wire logic sysref_realign_i,
  input wire logic oscillator_sync_i,
  input wire logic oscillator_phase_mismatch_i,
  input wire logic divider_mismatch_i,
  // Status pin selection and output
  input wire logic [1:0] status_pin_sel_i,
  input wire logic calibration_status_i,
  output logic status_output_pin_o
);
  import caa_pkg::*;

  localparam int NS = 8 + `CAA_NUM_LANES;

  logic [5:0] alarm_flags;
  logic [5:0] next_alarm_flags;
  logic [5:0] alarm_disable_bits;
  logic [5:0] next_alarm_disable_bits;
  logic [`CAA_NUM_LANES-1:0] per_lane_buffer_faults;
  logic [`CAA_NUM_LANES-1:0] next_per_lane_buffer_faults;
  caa_byte_t rdata;
  caa_byte_t next_rdata;
  logic rvalid;
  logic next_rvalid;
  logic pin;
  logic next_pin;
  logic link_en_d;
  logic realign_d;
  logic sysref_d;
  logic osc_sync_d;

  logic [NS-1:0] raw;
  logic [NS-1:0] synced;
  logic [`CAA_NUM_LANES-1:0] s_lane_fault;
  logic s_lock;
  logic s_link_en;
  logic s_data;
  logic s_realign;
  logic s_sysref;
  logic s_osc_sync;
  logic s_osc_mis;
  logic s_div_mis;

  // Encoding is quasi-static configuration, not synchronised
  assign raw = {lane_buffer_fault_i & lane_active_i, pll_locked_i, link_enable_i,
                link_in_data_state_i, link_realign_i, sysref_realign_i,
                oscillator_sync_i, oscillator_phase_mismatch_i, divider_mismatch_i};

  caa_sync #(.W(NS)) u_sync (
    .sys_clk_i(sys_clk_i),
    .reset_n_i(reset_n_i),
    .async_i(raw),
    .sync_o(synced)
  );

  assign s_lane_fault = synced[NS-1:8];
  assign s_lock = synced[7];
  assign s_link_en = synced[6];
  assign s_data = synced[5];
  assign s_realign = synced[4];
  assign s_sysref = synced[3];
  assign s_osc_sync = synced[2];
  assign s_osc_mis = synced[1];
  assign s_div_mis = synced[0];

  function automatic logic hit(input logic [`CAA_ADDR_W-1:0] a,
                               input logic [`CAA_ADDR_W-1:0] b);
    hit = (a == b);
  endfunction : hit

  function automatic logic rise(input logic now, input logic was);
    rise = now & ~was;
  endfunction : rise

  logic [5:0] set_cond;
  logic [5:0] clr_flags;
  logic [`CAA_NUM_LANES-1:0] set_lane;
  logic [`CAA_NUM_LANES-1:0] clr_lane;
  logic summary;

  // Levels re-set every cycle; events fire once per edge
  always_comb begin
    set_lane = s_lane_fault;
    set_cond = '0;
    set_cond[`CAA_BIT_LANE] = |s_lane_fault;
    set_cond[`CAA_BIT_LOCK] = ~s_lock;
    if (link_encoding_i == CAA_MODE_8B10B) begin
      set_cond[`CAA_BIT_LINK] = s_link_en & ~s_data;
    end else begin
      set_cond[`CAA_BIT_LINK] = rise(s_link_en, link_en_d) |
                                (s_link_en & rise(s_realign, realign_d));
    end
    set_cond[`CAA_BIT_REALIGN] = rise(s_sysref, sysref_d);
    set_cond[`CAA_BIT_OSC] = ~s_link_en | rise(s_osc_sync, osc_sync_d) | s_osc_mis;
    set_cond[`CAA_BIT_DIVIDER] = s_div_mis;

    clr_flags = '0;
    clr_lane = '0;
    if (reg_wr_i) begin
      if (hit(reg_addr_i, `CAA_ADDR_FLAGS)) begin
        clr_flags = reg_wdata_i[5:0];
        if (reg_wdata_i[`CAA_BIT_LANE]) begin
          clr_lane = '1;
        end
      end else if (hit(reg_addr_i, `CAA_ADDR_LANE_LO)) begin
        clr_lane[7:0] = reg_wdata_i;
      end else if (hit(reg_addr_i, `CAA_ADDR_LANE_HI)) begin
        clr_lane[15:8] = reg_wdata_i;
      end
    end

    next_alarm_flags = (alarm_flags & ~clr_flags) | set_cond;
    next_per_lane_buffer_faults = (per_lane_buffer_faults & ~clr_lane) | set_lane;
    next_alarm_disable_bits = alarm_disable_bits;
    if (reg_wr_i && hit(reg_addr_i, `CAA_ADDR_DISABLE)) begin
      next_alarm_disable_bits = reg_wdata_i[5:0];
    end
    // Soft reset last, so it overrides both set and clear
    if (soft_reset_i) begin
      next_alarm_flags = `CAA_FLAGS_RESET;
      next_alarm_disable_bits = `CAA_DISABLE_RESET;
      next_per_lane_buffer_faults = `CAA_LANE_RESET;
    end

    summary = |(alarm_flags & ~alarm_disable_bits);

    next_rvalid = reg_rd_i;
    next_rdata = '0;
    if (reg_rd_i) begin
      if (hit(reg_addr_i, `CAA_ADDR_SUMMARY)) begin
        next_rdata[`CAA_BIT_SUMMARY] = summary;
      end else if (hit(reg_addr_i, `CAA_ADDR_FLAGS)) begin
        next_rdata = {2'h0, alarm_flags};
      end else if (hit(reg_addr_i, `CAA_ADDR_DISABLE)) begin
        next_rdata = {2'h0, alarm_disable_bits};
      end else if (hit(reg_addr_i, `CAA_ADDR_LANE_LO)) begin
        next_rdata = per_lane_buffer_faults[7:0];
      end else if (hit(reg_addr_i, `CAA_ADDR_LANE_HI)) begin
        next_rdata = per_lane_buffer_faults[15:8];
      end
    end

    // Pin shows calibration status unless the alarm is selected
    if (status_pin_sel_i == `CAA_PIN_SEL_ALARM) begin
      next_pin = summary;
    end else begin
      next_pin = calibration_status_i;
    end
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      alarm_flags <= `CAA_FLAGS_RESET;
      alarm_disable_bits <= `CAA_DISABLE_RESET;
      per_lane_buffer_faults <= `CAA_LANE_RESET;
      rdata <= '0;
      rvalid <= 1'b0;
      pin <= 1'b0;
      link_en_d <= 1'b0;
      realign_d <= 1'b0;
      sysref_d <= 1'b0;
      osc_sync_d <= 1'b0;
    end else begin
      alarm_flags <= next_alarm_flags;
      alarm_disable_bits <= next_alarm_disable_bits;
      per_lane_buffer_faults <= next_per_lane_buffer_faults;
      rdata <= next_rdata;
      rvalid <= next_rvalid;
      pin <= next_pin;
      link_en_d <= s_link_en;
      realign_d <= s_realign;
      sysref_d <= s_sysref;
      osc_sync_d <= s_osc_sync;
    end
  end

  assign reg_rdata_o = rdata;
  assign reg_rvalid_o = rvalid;
  assign status_output_pin_o = pin;
endmodule : caa_alarm_aggregator
`default_nettype wire

// ==== caa_alarm_aggregator_checker.sv ====
// Port assertions for the converter alarm aggregator
`timescale 1ns/1ps
`default_nettype none
`include "caa_cfg.svh"
module caa_alarm_aggregator_checker
  import caa_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  input wire logic soft_reset_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [`CAA_ADDR_W-1:0] reg_addr_i,
  input wire caa_byte_t reg_rdata_o,
  input wire logic [`CAA_NUM_LANES-1:0] lane_buffer_fault_i,
  input wire logic [`CAA_NUM_LANES-1:0] lane_active_i,
  input wire logic pll_locked_i,
  input wire logic oscillator_phase_mismatch_i,
  input wire logic divider_mismatch_i,
  input wire logic [1:0] status_pin_sel_i,
  input wire logic calibration_status_i,
  input wire logic status_output_pin_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!reset_n_i);
  // Six cycles of a level leaves room for the synchroniser lag
  wire rd_flags = reg_rd_i && reg_addr_i == `CAA_ADDR_FLAGS;
  wire wr_flags = reg_wr_i && reg_addr_i == `CAA_ADDR_FLAGS;
  chk_summary_upper_zero: assert property (
    reg_rd_i && reg_addr_i == `CAA_ADDR_SUMMARY |=> reg_rdata_o[7:1] == 7'h00)
    else $error("summary upper bits set");
  chk_pin_passes_cal: assert property (
    status_pin_sel_i != `CAA_PIN_SEL_ALARM |=> status_output_pin_o == $past(calibration_status_i))
    else $error("pin not following calibration status");
  chk_lane_sets_flag: assert property (
    (|(lane_buffer_fault_i & lane_active_i))[*6] ##1 rd_flags |=> reg_rdata_o[5])
    else $error("lane fault flag missing");
  chk_lock_sets_flag: assert property ((!pll_locked_i)[*6] ##1 rd_flags |=> reg_rdata_o[4])
    else $error("lock loss flag missing");
  chk_osc_sets_flag: assert property (
    oscillator_phase_mismatch_i[*6] ##1 rd_flags |=> reg_rdata_o[1])
    else $error("oscillator flag missing");
  chk_div_sets_flag: assert property (divider_mismatch_i[*6] ##1 rd_flags |=> reg_rdata_o[0])
    else $error("divider flag missing");
  chk_soft_flags: assert property (soft_reset_i ##1 rd_flags |=> reg_rdata_o == 8'h3f)
    else $error("flags not set by soft reset");
  chk_soft_mask: assert property (
    soft_reset_i ##1 reg_rd_i && reg_addr_i == `CAA_ADDR_DISABLE |=> reg_rdata_o == 8'h3f)
    else $error("mask not set by soft reset");
  chk_set_beats_clear: assert property (
    (!pll_locked_i)[*6] ##0 wr_flags ##1 rd_flags |=> reg_rdata_o[4])
    else $error("clear beat a standing fault");
  cover property (soft_reset_i ##1 rd_flags);
  cover property (status_pin_sel_i == `CAA_PIN_SEL_ALARM && status_output_pin_o);
  cover property (!pll_locked_i ##0 wr_flags);
endmodule : caa_alarm_aggregator_checker
bind caa_alarm_aggregator caa_alarm_aggregator_checker caa_alarm_aggregator_checker_i (.*);
`default_nettype wire

// ==== tb_caa_alarm_aggregator.sv ====
// Self-checking bench for the converter alarm aggregator
`timescale 1ns/1ps
`default_nettype none
`include "caa_cfg.svh"
module tb_caa_alarm_aggregator;
  import caa_pkg::*;
  typedef struct {logic w; logic [14:0] a; caa_byte_t d;} caa_row_s;
  logic clk = 0, rst_n = 0, srst = 0, wr = 0, rd = 0, cal = 0, rv, pin;
  logic [14:0] addr = 0;
  logic [5:0] src = 0;
  logic [15:0] act = 16'hffff;
  logic len = 1, lrealign = 0, osync = 0;
  caa_encoding_e enc = CAA_MODE_8B10B;
  logic [1:0] sel = 0;
  caa_byte_t wd = 0, rdat;
  int n_fail = 0, n_checks = 0, cyc = 0;
  caa_row_s rows[13] = '{'{0, `CAA_ADDR_FLAGS, 8'h3f}, '{0, `CAA_ADDR_DISABLE, 8'h3f},
    '{0, `CAA_ADDR_SUMMARY, 8'h00}, '{0, `CAA_ADDR_LANE_HI, 8'hff}, '{1, `CAA_ADDR_FLAGS, 8'h01},
    '{0, `CAA_ADDR_FLAGS, 8'h3e}, '{1, `CAA_ADDR_DISABLE, 8'h1f}, '{0, `CAA_ADDR_SUMMARY, 8'h01},
    '{1, `CAA_ADDR_FLAGS, 8'h20}, '{0, `CAA_ADDR_LANE_LO, 8'h00}, '{1, `CAA_ADDR_SUMMARY, 8'hff},
    '{0, `CAA_ADDR_SUMMARY, 8'h00}, '{0, 15'h02c3, 8'h00}};
  caa_alarm_aggregator caa_alarm_aggregator_i (.sys_clk_i(clk), .reset_n_i(rst_n),
    .soft_reset_i(srst), .reg_wr_i(wr), .reg_rd_i(rd), .reg_addr_i(addr), .reg_wdata_i(wd),
    .reg_rdata_o(rdat), .reg_rvalid_o(rv), .lane_buffer_fault_i({16{src[5]}}),
    .lane_active_i(act), .pll_locked_i(!src[4]), .link_enable_i(len),
    .link_encoding_i(enc), .link_in_data_state_i(!src[3]), .link_realign_i(lrealign),
    .sysref_realign_i(src[2]), .oscillator_sync_i(osync), .oscillator_phase_mismatch_i(src[1]),
    .divider_mismatch_i(src[0]), .status_pin_sel_i(sel), .calibration_status_i(cal),
    .status_output_pin_o(pin));
  initial forever #25 clk = ~clk;
  task automatic print_verdict();
    if (n_fail == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : print_verdict
  task automatic chk(input caa_byte_t g, input caa_byte_t e);
    n_checks++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value at %0t: got %h want %h", $time, g, e);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #5;
  endtask : tick
  task automatic wr_t(input logic [14:0] a, input caa_byte_t d);
    wr = 1;
    addr = a;
    wd = d;
    tick(1);
    wr = 0;
  endtask : wr_t
  // Read data only counts when the valid pulse is there
  task automatic rd_t(input logic [14:0] a, input caa_byte_t e);
    rd = 1;
    addr = a;
    tick(1);
    rd = 0;
    chk(rv === 1'b1 ? rdat : 8'hxx, e);
  endtask : rd_t
  task automatic soft_t();
    srst = 1;
    tick(1);
    srst = 0;
  endtask : soft_t
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_fail++;
      print_verdict();
    end
  end
  initial begin
    tick(3);
    rst_n = 1;
    tick(10);
    for (int i = 0; i < 13; i++) begin
      if (rows[i].w) wr_t(rows[i].a, rows[i].d);
      else rd_t(rows[i].a, rows[i].d);
      // Idle edge so a strobe is never lowered and raised in one step
      tick(1);
    end
    wr_t(`CAA_ADDR_DISABLE, 8'h00);
    sel = `CAA_PIN_SEL_ALARM;
    for (int i = 0; i < 6; i++) begin
      wr_t(`CAA_ADDR_FLAGS, 8'h3f);
      rd_t(`CAA_ADDR_FLAGS, 8'h00);
      chk({7'h0, pin}, 8'h00);
      src = 6'h01 << i;
      tick(8);
      rd_t(`CAA_ADDR_FLAGS, 8'h01 << i);
      chk({7'h0, pin}, 8'h01);
      src = 0;
      tick(8);
    end
    // 64b/66b: data state ignored, start-up and realign edges count
    enc = CAA_MODE_64B66B;
    src = 6'h08;
    tick(8);
    wr_t(`CAA_ADDR_FLAGS, 8'h3f);
    tick(8);
    rd_t(`CAA_ADDR_FLAGS, 8'h00);
    lrealign = 1;
    tick(8);
    rd_t(`CAA_ADDR_FLAGS, 8'h08);
    wr_t(`CAA_ADDR_FLAGS, 8'h3f);
    rd_t(`CAA_ADDR_FLAGS, 8'h00);
    lrealign = 0;
    len = 0;
    tick(8);
    wr_t(`CAA_ADDR_FLAGS, 8'h3f);
    rd_t(`CAA_ADDR_FLAGS, 8'h02);
    len = 1;
    tick(8);
    rd_t(`CAA_ADDR_FLAGS, 8'h0a);
    wr_t(`CAA_ADDR_FLAGS, 8'h3f);
    osync = 1;
    tick(8);
    rd_t(`CAA_ADDR_FLAGS, 8'h02);
    osync = 0;
    src = 6'h00;
    tick(8);
    enc = CAA_MODE_8B10B;
    // Only active lanes may raise a lane fault
    act = 16'h0100;
    src = 6'h20;
    tick(8);
    wr_t(`CAA_ADDR_FLAGS, 8'h3f);
    rd_t(`CAA_ADDR_LANE_LO, 8'h00);
    tick(1);
    rd_t(`CAA_ADDR_LANE_HI, 8'h01);
    src = 6'h00;
    tick(8);
    wr_t(`CAA_ADDR_LANE_HI, 8'h01);
    rd_t(`CAA_ADDR_LANE_HI, 8'h00);
    tick(1);
    rd_t(`CAA_ADDR_FLAGS, 8'h20);
    act = 16'hffff;
    wr_t(`CAA_ADDR_FLAGS, 8'h3f);
    src = 6'h10;
    tick(8);
    wr_t(`CAA_ADDR_FLAGS, 8'h10);
    rd_t(`CAA_ADDR_FLAGS, 8'h10);
    src = 0;
    tick(8);
    rd_t(`CAA_ADDR_FLAGS, 8'h10);
    sel = 2'h0;
    tick(2);
    chk({7'h0, pin}, 8'h00);
    cal = 1;
    tick(2);
    chk({7'h0, pin}, 8'h01);
    soft_t();
    rd_t(`CAA_ADDR_DISABLE, 8'h3f);
    wr_t(`CAA_ADDR_FLAGS, 8'h3f);
    soft_t();
    rd_t(`CAA_ADDR_FLAGS, 8'h3f);
    tick(1);
    rd_t(`CAA_ADDR_LANE_HI, 8'hff);
    // Mid-run reset: outputs drop at once, flags come back set
    wr_t(`CAA_ADDR_FLAGS, 8'h3f);
    rst_n = 0;
    tick(1);
    chk({6'h0, rv, pin}, 8'h00);
    rst_n = 1;
    rd_t(`CAA_ADDR_FLAGS, 8'h3f);
    print_verdict();
  end
endmodule : tb_caa_alarm_aggregator
`default_nettype wire
